// ### src/rbms_pkg.sv
`default_nettype none
package rbms_pkg;
    // ==========================================================
    // Timing
    localparam int          CLK_NS      = 25;
    localparam int          RECOVER_NS  = 2_000_000;
    localparam int          RECOVER_CYC = RECOVER_NS / CLK_NS;
    localparam int          RCV_W       = 17;
    // Host must use the one baud rate set here; divider is fixed at build time
    localparam logic [15:0] BIT_CYC     = 16'h015B;
    localparam logic [15:0] HALF_CYC    = 16'h00AD;
    localparam logic [3:0]  STOP_BIT    = 4'h9;
    localparam logic [3:0]  START_BIT   = 4'h0;

    // ==========================================================
    // Boot data
    localparam int          DATA_W      = 8;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          PWD_BYTES   = 12;
    localparam logic [3:0]  PWD_LAST    = 4'hB;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [31:0] RAM_LOAD    = 32'h2000_0800;
    localparam logic [31:0] RAM_LAST    = 32'h2000_7FFF;
    localparam logic [31:0] FLASH_NORM  = 32'h0000_0000;
    localparam logic [31:0] FLASH_BOOT  = 32'h3F80_0000;

    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_PWD   = 4'h2,
        ST_LOAD  = 4'h4,
        ST_ABORT = 4'h8
    } rbms_state_t;

    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [7:0]  data;
    } rbms_ram_wr_t;
endpackage
`default_nettype wire

// ### src/rbms_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rbms_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         i_clk,     // Core clock
    input  wire logic         i_rst_n,   // Synchronised reset
    input  wire logic         i_valid,   // Write request
    output logic              o_ready,   // Not full
    input  wire logic [W-1:0] i_data,    // Write data
    output logic              o_valid,   // Not empty
    input  wire logic         i_ready,   // Read accept
    output logic [W-1:0]      o_data     // Head word
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    logic         push;
    logic         pop;

    assign o_ready = (wp_ff[AW] == rp_ff[AW])
                     || (wp_ff[AW-1:0] != rp_ff[AW-1:0]);
    assign o_valid = (wp_ff != rp_ff);
    assign o_data  = mem[rp_ff[AW-1:0]];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_ff[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/rbms_top.sv
`timescale 1ns/1ps
`default_nettype none
module rbms_top #(
    parameter int RECOVER_CYC = rbms_pkg::RECOVER_CYC
) (
    input  wire logic           i_core_clk,       // 40 MHz core clock
    input  wire logic           i_rst_n,          // Async reset, low
    input  wire logic           i_strap,          // Mode strap level
    input  wire logic           i_flash_abort,    // Flash op was cut
    input  wire logic           i_flash_erase_mode, // Array busy
    input  wire logic           i_gear_change,    // Software gear pulse
    input  wire logic [95:0]    i_pwd_stored,     // Stored password
    input  wire logic           i_pwd_erased,     // Password block blank
    input  wire logic           i_rx,             // Channel zero RX
    input  wire logic           i_ram_ready,      // RAM accepts write
    output logic                o_boot_rom_map,   // Boot ROM at zero
    output logic [31:0]         o_flash_base,     // Flash base address
    output logic                o_gear_full,      // Undivided gear
    output logic                o_flash_rd_en,    // Flash reads allowed
    output logic                o_array_normal,   // Array normal mode
    output logic                o_pwd_ok,         // Password matched
    output logic                o_pwd_fail,       // Download aborted
    output logic                o_rx_hold,        // Buffer full
    output logic                o_overrun,        // Byte lost
    output var rbms_pkg::rbms_ram_wr_t o_ram_wr   // RAM write port
);
    // ==========================================================
    // Reset release
    logic rst_a_ff;
    logic rst_n_s;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_a_ff <= 1'b0;
            rst_n_s  <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n_s  <= rst_a_ff;
        end
    end

    // ==========================================================
    // Mode strap and maps
    logic                    latched_ff;
    logic                    boot_ff;
    logic [rbms_pkg::RCV_W-1:0] rcv_ff;

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            latched_ff <= 1'b0;
            boot_ff    <= 1'b0;
        end else if (!latched_ff) begin
            latched_ff <= 1'b1;
            boot_ff    <= !i_strap;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            o_boot_rom_map <= 1'b0;
            o_flash_base   <= rbms_pkg::FLASH_NORM;
        end else begin
            o_boot_rom_map <= boot_ff;
            o_flash_base   <= boot_ff ? rbms_pkg::FLASH_BOOT
                                      : rbms_pkg::FLASH_NORM;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            o_gear_full <= 1'b1;
        end else if (i_gear_change) begin
            o_gear_full <= 1'b0;
        end
    end

    // ==========================================================
    // Flash read gate
    // The aborted-operation flag is caught after release, never in reset
    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rcv_ff <= '0;
        end else if (!latched_ff && i_flash_abort) begin
            rcv_ff <= rbms_pkg::RCV_W'(RECOVER_CYC);
        end else if (rcv_ff != '0) begin
            rcv_ff <= rcv_ff - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            o_flash_rd_en  <= 1'b0;
            o_array_normal <= 1'b1;
        end else begin
            o_flash_rd_en  <= latched_ff && (rcv_ff == '0)
                              && !i_flash_erase_mode;
            o_array_normal <= !i_flash_erase_mode;
        end
    end

    // ==========================================================
    // Serial receiver
    logic        rx_busy_ff;
    logic [15:0] rx_cnt_ff;
    logic [3:0]  rx_bit_ff;
    logic [7:0]  rx_sh_ff;
    logic        rx_vld_ff;

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rx_busy_ff <= 1'b0;
            rx_cnt_ff  <= '0;
            rx_bit_ff  <= '0;
            rx_sh_ff   <= '0;
            rx_vld_ff  <= 1'b0;
        end else begin
            rx_vld_ff <= 1'b0;
            if (!rx_busy_ff) begin
                if (boot_ff && !i_rx) begin
                    rx_busy_ff <= 1'b1;
                    rx_cnt_ff  <= rbms_pkg::HALF_CYC;
                    rx_bit_ff  <= rbms_pkg::START_BIT;
                end
            end else if (rx_cnt_ff != '0) begin
                rx_cnt_ff <= rx_cnt_ff - 1'b1;
            end else begin
                rx_cnt_ff <= rbms_pkg::BIT_CYC;
                rx_bit_ff <= rx_bit_ff + 1'b1;
                if (rx_bit_ff == rbms_pkg::START_BIT) begin
                    rx_busy_ff <= !i_rx; // Glitch rejects the frame
                end else if (rx_bit_ff == rbms_pkg::STOP_BIT) begin
                    rx_busy_ff <= 1'b0;
                    rx_vld_ff  <= i_rx;
                end else begin
                    rx_sh_ff <= {i_rx, rx_sh_ff[7:1]};
                end
            end
        end
    end

    // ==========================================================
    // Password check
    function automatic logic [7:0] pwd_byte(input logic [95:0] pwd,
                                            input logic        erased,
                                            input logic [3:0]  idx);
        pwd_byte = erased ? rbms_pkg::ERASED_BYTE
                          : pwd[idx*rbms_pkg::DATA_W +: rbms_pkg::DATA_W];
    endfunction

    rbms_pkg::rbms_state_t state_ff;
    logic [3:0]            pwd_idx_ff;
    logic                  miss_ff;
    logic                  miss_now;

    assign miss_now = miss_ff
        || (rx_sh_ff != pwd_byte(i_pwd_stored, i_pwd_erased, pwd_idx_ff));

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_ff   <= rbms_pkg::ST_RUN;
            pwd_idx_ff <= '0;
            miss_ff    <= 1'b0;
        end else begin
            unique case (state_ff)
                rbms_pkg::ST_RUN: begin
                    if (latched_ff && boot_ff) begin
                        state_ff <= rbms_pkg::ST_PWD;
                    end
                end
                rbms_pkg::ST_PWD: begin
                    if (rx_vld_ff) begin
                        miss_ff    <= miss_now;
                        pwd_idx_ff <= pwd_idx_ff + 1'b1;
                        if (pwd_idx_ff == rbms_pkg::PWD_LAST) begin
                            state_ff <= miss_now ? rbms_pkg::ST_ABORT
                                                 : rbms_pkg::ST_LOAD;
                        end
                    end
                end
                rbms_pkg::ST_LOAD: state_ff <= rbms_pkg::ST_LOAD;
                rbms_pkg::ST_ABORT: state_ff <= rbms_pkg::ST_ABORT;
                default: state_ff <= rbms_pkg::ST_RUN;
            endcase
        end
    end

    // ==========================================================
    // Download buffer and RAM writer
    logic       f_ready;
    logic       f_valid;
    logic [7:0] f_data;
    logic       f_pop;
    logic       push_req;

    assign push_req = rx_vld_ff && (state_ff == rbms_pkg::ST_LOAD);
    assign f_pop    = f_valid && i_ram_ready
                      && (o_ram_wr.we ? (o_ram_wr.addr < rbms_pkg::RAM_LAST)
                                      : (o_ram_wr.addr <= rbms_pkg::RAM_LAST));

    rbms_fifo #(
        .W (rbms_pkg::DATA_W),
        .D (rbms_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_n_s),
        .i_valid (push_req),
        .o_ready (f_ready),
        .i_data  (rx_sh_ff),
        .o_valid (f_valid),
        .i_ready (f_pop),
        .o_data  (f_data)
    );

    // Address starts at the load base; past RAM end the writer stalls
    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            o_ram_wr.we   <= 1'b0;
            o_ram_wr.addr <= rbms_pkg::RAM_LOAD;
            o_ram_wr.data <= '0;
        end else begin
            o_ram_wr.we <= f_pop;
            if (f_pop) begin
                o_ram_wr.data <= f_data;
            end
            if (o_ram_wr.we) begin
                o_ram_wr.addr <= o_ram_wr.addr + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            o_pwd_ok   <= 1'b0;
            o_pwd_fail <= 1'b0;
            o_rx_hold  <= 1'b0;
            o_overrun  <= 1'b0;
        end else begin
            o_pwd_ok   <= (state_ff == rbms_pkg::ST_LOAD);
            o_pwd_fail <= (state_ff == rbms_pkg::ST_ABORT);
            o_rx_hold  <= !f_ready;
            if (push_req && !f_ready) begin
                o_overrun <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n_s);
    rom_map_a: assert property (boot_ff ##1 boot_ff |->
        o_boot_rom_map && o_flash_base == rbms_pkg::FLASH_BOOT)
        else $error("boot map not applied");
    flash_map_a: assert property (latched_ff && !boot_ff |=>
        !o_boot_rom_map && o_flash_base == rbms_pkg::FLASH_NORM)
        else $error("normal map not applied");
    mode_hold_a: assert property (latched_ff |=> $stable(boot_ff))
        else $error("boot mode changed");
    erase_block_a: assert property (i_flash_erase_mode |=>
        !o_flash_rd_en) else $error("read during erase");
    recover_a: assert property (rcv_ff != '0 |=> !o_flash_rd_en)
        else $error("read during recovery");
    gear_reset_a: assert property ($rose(latched_ff) &&
        !$past(i_gear_change) |-> o_gear_full)
        else $error("gear not undivided");
    pwd_count_a: assert property ($rose(state_ff == rbms_pkg::ST_LOAD)
        |-> $past(pwd_idx_ff) == rbms_pkg::PWD_LAST)
        else $error("load before 12 bytes");
    abort_quiet_a: assert property (state_ff == rbms_pkg::ST_ABORT
        |=> !o_ram_wr.we [*3]) else $error("write after abort");
    ram_range_a: assert property (o_ram_wr.we |->
        o_ram_wr.addr >= rbms_pkg::RAM_LOAD
        && o_ram_wr.addr <= rbms_pkg::RAM_LAST)
        else $error("RAM write out of range");
    load_c: cover property (state_ff == rbms_pkg::ST_LOAD ##[1:400]
        o_ram_wr.we);
    abort_c: cover property ($rose(state_ff == rbms_pkg::ST_ABORT));
    hold_c: cover property ($rose(o_rx_hold));
endmodule
`default_nettype wire

// ### bench/rbms_host.sv
`timescale 1ns/1ps
`default_nettype none
module rbms_host (
    input  wire logic i_clk,   // Core clock
    output logic      o_tx     // Line into channel zero
);
    // ==========================================================
    // Asynchronous host transmitter
    // Line rests high between frames, as a released line would
    initial o_tx = 1'b1;

    task automatic send(input logic [7:0] b, input int gap);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        repeat (gap) @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_tx <= frame[i];
            repeat (int'(rbms_pkg::BIT_CYC)) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// ### bench/reset_and_boot_mode_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module reset_and_boot_mode_select_bench;
    // ==========================================================
    // Signals
    // Recovery shortened so the gate can be watched end to end
    localparam int          RCV        = 20;
    localparam int          LIMIT      = 96000;
    // Reset lengths in core clocks; 20 clocks make 0.5 us
    localparam int          HOLD_MIN   = 12;
    localparam int          HOLD_FLASH = 20;
    logic                   i_core_clk;
    logic                   i_rst_n;
    logic                   i_strap;
    logic                   i_flash_abort;
    logic                   i_flash_erase_mode;
    logic                   i_gear_change;
    logic [95:0]            i_pwd_stored;
    logic                   i_pwd_erased;
    wire                    i_rx;
    logic                   i_ram_ready;
    logic                   o_boot_rom_map;
    logic [31:0]            o_flash_base;
    logic                   o_gear_full;
    logic                   o_flash_rd_en;
    logic                   o_array_normal;
    logic                   o_pwd_ok;
    logic                   o_pwd_fail;
    logic                   o_rx_hold;
    logic                   o_overrun;
    rbms_pkg::rbms_ram_wr_t o_ram_wr;
    int                     errors;
    int                     tests_run;
    int                     cycles;
    logic [31:0]            exp_addr;
    logic [7:0]             exp_q[$];
    logic [7:0]             b;
    logic [7:0]             exp_b;

    rbms_top #(.RECOVER_CYC(RCV)) dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_strap(i_strap),
        .i_flash_abort(i_flash_abort),
        .i_flash_erase_mode(i_flash_erase_mode),
        .i_gear_change(i_gear_change), .i_pwd_stored(i_pwd_stored),
        .i_pwd_erased(i_pwd_erased), .i_rx(i_rx),
        .i_ram_ready(i_ram_ready), .o_boot_rom_map(o_boot_rom_map),
        .o_flash_base(o_flash_base), .o_gear_full(o_gear_full),
        .o_flash_rd_en(o_flash_rd_en), .o_array_normal(o_array_normal),
        .o_pwd_ok(o_pwd_ok), .o_pwd_fail(o_pwd_fail),
        .o_rx_hold(o_rx_hold), .o_overrun(o_overrun),
        .o_ram_wr(o_ram_wr));

    rbms_host host (.i_clk(i_core_clk), .o_tx(i_rx));

    // ==========================================================
    // Checking and reporting
    task automatic fail(input string msg);
        errors++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
        tests_run++;
        if (got !== exp) fail(m);
    endtask

    task automatic complete_run;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [31:0] exp_base(input logic serial);
        return serial ? rbms_pkg::FLASH_BOOT : rbms_pkg::FLASH_NORM;
    endfunction

    task automatic chk_mode(input logic serial);
        chk_bit(o_boot_rom_map, serial, "boot rom map");
        chk_word(o_flash_base, exp_base(serial), "flash base");
    endtask

    // Strap is flipped after release to show the mode no longer follows it
    task automatic do_reset(input logic strap, input logic abort);
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        i_strap <= strap;
        i_flash_abort <= abort;
        repeat (abort ? HOLD_FLASH : HOLD_MIN) @(posedge i_core_clk);
        chk_bit(o_array_normal, 1'b1, "array normal in reset");
        chk_bit(o_gear_full, 1'b1, "gear undivided in reset");
        i_flash_erase_mode <= 1'b0;
        i_rst_n <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_strap <= ~strap;
        i_flash_abort <= 1'b0;
    endtask

    // ==========================================================
    // Clock, timeout, RAM side
    always #12.5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail("timeout");
            complete_run;
        end
    end

    always @(posedge i_core_clk) begin
        i_ram_ready <= 1'($urandom_range(0, 1));
        if (i_rst_n !== 1'b1) begin
            exp_addr = rbms_pkg::RAM_LOAD;
        end else if (o_ram_wr.we === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("ram write without download");
            end else begin
                exp_b = exp_q.pop_front();
                chk_word(o_ram_wr.addr, exp_addr, "ram address");
                chk_word(32'(o_ram_wr.data), 32'(exp_b), "ram data");
                exp_addr = exp_addr + 32'h1;
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        i_core_clk = 1'b0;
        i_rst_n = 1'b0;
        i_strap = 1'b1;
        i_flash_abort = 1'b0;
        i_flash_erase_mode = 1'b0;
        i_gear_change = 1'b0;
        i_pwd_stored = 96'h0;
        i_pwd_erased = 1'b0;
        i_ram_ready = 1'b0;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        void'($urandom(51));
        // Power-on hold is far below the cold-start minimum; nothing times it
        repeat (8) @(posedge i_core_clk);
        do_reset(1'b1, 1'b0);
        repeat (3) @(posedge i_core_clk);
        chk_mode(1'b0);
        chk_bit(o_flash_rd_en, 1'b1, "flash readable");
        chk_bit(o_pwd_ok, 1'b0, "no password in normal boot");
        i_gear_change <= 1'b1;
        @(posedge i_core_clk);
        i_gear_change <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        chk_bit(o_gear_full, 1'b0, "gear left undivided");
        i_flash_erase_mode <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        chk_bit(o_flash_rd_en, 1'b0, "reads during erase");
        chk_bit(o_array_normal, 1'b0, "array busy");
        do_reset(1'b1, 1'b1);
        chk_bit(o_flash_rd_en, 1'b0, "reads in recovery");
        repeat (RCV - 2) @(posedge i_core_clk);
        chk_bit(o_flash_rd_en, 1'b0, "recovery cut short");
        @(posedge i_core_clk);
        chk_bit(o_flash_rd_en, 1'b1, "reads after recovery");
        // Erased block: stored bytes are ignored, all ones must match
        i_pwd_erased <= 1'b1;
        i_pwd_stored <= {$urandom, $urandom, $urandom};
        do_reset(1'b0, 1'b0);
        chk_mode(1'b1);
        for (int k = 0; k < rbms_pkg::PWD_BYTES; k++) begin
            host.send(rbms_pkg::ERASED_BYTE, $urandom_range(0, 20));
        end
        repeat (4) @(posedge i_core_clk);
        chk_bit(o_pwd_ok, 1'b1, "erased password match");
        chk_bit(o_pwd_fail, 1'b0, "no abort on match");
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            host.send(b, 0);
        end
        repeat (40) @(posedge i_core_clk);
        chk_word(32'(exp_q.size()), 32'h0, "bytes not written");
        chk_bit(o_overrun, 1'b0, "no lost byte");
        chk_bit(o_rx_hold, 1'b0, "buffer not drained");
        // Wrong last byte must abort the whole download
        i_pwd_erased <= 1'b0;
        do_reset(1'b0, 1'b0);
        for (int k = 0; k < rbms_pkg::PWD_BYTES; k++) begin
            b = i_pwd_stored[8*k +: 8];
            host.send((k == 11) ? ~b : b, $urandom_range(0, 20));
        end
        repeat (40) @(posedge i_core_clk);
        chk_bit(o_pwd_fail, 1'b1, "mismatch aborts");
        chk_bit(o_pwd_ok, 1'b0, "mismatch not accepted");
        complete_run;
    end
endmodule
`default_nettype wire
